// File: dv/acs_conv_model.sv
// Behavioural converter core that reports finished samples and result events
`timescale 1ns/1ns
module acs_conv_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i, // Start one sample
    input wire logic slow_i, // Use the long conversion time
    input wire logic wr_i, // Report a buffer write
    input wire logic match_i, // Report a compare match
    input wire logic [3:0] chan_i, // Result channel of the sample
    output logic sample_done_o,
    output acs_pkg::acs_event_s event_o
);
    import acs_pkg::*;
    logic [2:0] wait_q; // Cycles left in the running sample
    logic busy_q; // A sample is running
    acs_event_s ev_q; // Event held until the sample ends
    // Pulses last one cycle, then the lines return to no event
    always_ff @(posedge clk_i) begin
        sample_done_o <= 1'b0;
        event_o <= '0;
        if (rst_i) begin
            busy_q <= 1'b0;
            wait_q <= 3'h0;
            ev_q <= '0;
        end else if (go_i && !busy_q) begin
            busy_q <= 1'b1;
            wait_q <= slow_i ? 3'h5 : 3'h1;
            ev_q <= '{result_write: wr_i, match: match_i, channel: chan_i};
        end else if (busy_q && wait_q == 3'h0) begin
            busy_q <= 1'b0;
            sample_done_o <= 1'b1;
            event_o <= ev_q;
        end else if (busy_q) begin
            wait_q <= wait_q - 3'h1;
        end
    end
endmodule

// File: dv/acs_scan_select_monitor.sv
// Port checker for the channel and scan selection block
`timescale 1ns/1ns
module acs_scan_select_monitor #(
    parameter int DIV_WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [DIV_WIDTH-1:0] conv_clock_divider_i,
    input wire logic conv_clock_tick_o,
    input wire logic [2:0] bg_request_i,
    input wire logic [2:0] bg_ready_o,
    input wire logic [4:0] scan_channel_o,
    input wire acs_pkg::acs_route_s route_o
);
    import acs_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic [DIV_WIDTH-1:0] gap_q; // Enabled cycles since the last tick
    logic seen_q; // A tick was seen under a steady divider
    // Gap counter; a divider change or a frozen cycle restarts it, so no stale gap is judged
    always_ff @(posedge clk_i) begin
        if (rst_i || !ce_i || $changed(conv_clock_divider_i)) begin
            seen_q <= 1'b0;
            gap_q <= '0;
        end else if (conv_clock_tick_o) begin
            seen_q <= 1'b1;
            gap_q <= '0;
        end else begin
            gap_q <= gap_q + 1'b1;
        end
    end
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_reset_clear;
        $fell(rst_i) |-> bg_ready_o == 3'h0 && scan_channel_o == 5'h00 && !conv_clock_tick_o;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("output not clear after reset");
    property p_ext_index;
        route_o.ext_valid |-> route_o.ext_index <= 4'hd;
    endproperty
    a_ext_index: assert property (p_ext_index) else $error("external input above thirteen");
    property p_reserved_alone;
        route_o.reserved |-> !(route_o.ext_valid || route_o.bandgap || route_o.ground
            || route_o.supply || route_o.ctu_temp || route_o.ctu_general);
    endproperty
    a_reserved_alone: assert property (p_reserved_alone) else $error("reserved code routed");
    property p_internal_one;
        route_o.bandgap || route_o.ground || route_o.supply
            |-> !route_o.ext_valid && $onehot({route_o.bandgap, route_o.ground, route_o.supply});
    endproperty
    a_internal_one: assert property (p_internal_one) else $error("internal input clash");
    property p_tick_gap;
        conv_clock_tick_o && ce_i && seen_q && $stable(conv_clock_divider_i)
            |-> gap_q == conv_clock_divider_i;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong");
    property p_bg_wait;
        ce_i && $rose(bg_request_i[2]) && !bg_ready_o[2] |=> !bg_ready_o[2] [*4];
    endproperty
    a_bg_wait: assert property (p_bg_wait) else $error("reference ready too early");
    c_tick: cover property (conv_clock_tick_o);
    c_bg_ready: cover property ($rose(bg_ready_o[2]));
    c_wrap: cover property (scan_channel_o < $past(scan_channel_o));
endmodule

// File: dv/acs_scan_select_tb_top.sv
// Self-checking bench for the channel and scan selection block
`timescale 1ns/1ns
module acs_scan_select_tb_top;
    import acs_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic go = 1'b0, slow = 1'b0, ev_wr = 1'b0, ev_m = 1'b0;
    logic [3:0] ev_ch = 4'h0;
    logic [7:0] adr = 8'h00, div = 8'h02;
    logic [2:0] bg_req = 3'h0, bg_rdy;
    logic [31:0] wdat = 32'h0000_0000, rdat, dat_o;
    logic ack, done, tick, ctu;
    logic [4:0] scan_ch;
    acs_event_s ev;
    acs_route_s route;
    logic [7:0] flags; // Route flags without the input number
    int errors = 0, total_checks = 0, n, cnt;
    logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    logic [15:0] masks [7] = '{16'hffff, 16'h0007, 16'h3fff, 16'h1f00, 16'hffff, 16'h73ff, 16'hffff};
    logic [4:0] codes [10] = '{5'h00, 5'h05, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h1b, 5'h1c, 5'h1d, 5'h1e};
    logic [4:0] seq [4] = '{5'h01, 5'h04, 5'h18, 5'h01};
    assign flags = {route.ext_valid, route.ctu_temp, route.ctu_general, route.bandgap,
        route.ground, route.supply, route.reserved, route.neg_ground};
    // Free-running 125 MHz clock
    always #4 clk_i = ~clk_i;
    acs_scan_select #(.BG_STARTUP_CYC(8)) acs_scan_select_i (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .sample_done_i(done), .event_i(ev), .conv_clock_divider_i(div),
        .bg_request_i(bg_req), .route_o(route), .scan_channel_o(scan_ch),
        .ctu_connect_o(ctu), .conv_clock_tick_o(tick), .bg_ready_o(bg_rdy));
    acs_conv_model acs_conv_model_i (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .slow_i(slow),
        .wr_i(ev_wr), .match_i(ev_m), .chan_i(ev_ch), .sample_done_o(done), .event_o(ev));
    // Expected route flags of a positive code with the negative input on ground
    function automatic logic [7:0] exp_flags(input logic [4:0] c);
        exp_flags = {c <= 5'h0d, c == 5'h0e, c == 5'h0f, c == 5'h1c, c == 5'h1d, c == 5'h1e,
            c >= 5'h10 && c <= 5'h1b, 1'b1};
    endfunction
    // One classic bus cycle; the request holds until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 50);
        if (t >= 50) errors++;
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rdat);
    endtask
    // Ask the converter model for one sample, then let it finish
    task automatic conv(input logic w, input logic m, input logic [3:0] c);
        @(posedge clk_i);
        go <= 1'b1;
        ev_wr <= w;
        ev_m <= m;
        ev_ch <= c;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (12) @(posedge clk_i);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (offs[i]) rd_chk("reset", offs[i], 32'h0000_0000);
        foreach (offs[i]) begin
            wb(1'b1, offs[i], 32'h0000_ffff);
            rd_chk("mask", offs[i], {16'h0000, masks[i]});
            wb(1'b1, offs[i], 32'h0000_0000);
        end
        wb(1'b1, 8'h24, 32'h0000_ffff);
        rd_chk("unmapped", 8'h24, 32'h0000_0000);
        $display("test registers done");
        foreach (codes[i]) begin
            wb(1'b1, ACS_OFF_SAMPLE_SEL, {27'h000_0000, codes[i]});
            repeat (2) @(posedge clk_i);
            chk("route", {24'h00_0000, exp_flags(codes[i])}, {24'h00_0000, flags});
            if (codes[i] <= 5'h0d)
                chk("input", {27'h000_0000, codes[i]}, {28'h000_0000, route.ext_index});
        end
        wb(1'b1, ACS_OFF_SAMPLE_SEL, 32'h0000_0023);
        repeat (2) @(posedge clk_i);
        chk("negative", 32'h0000_0000, {31'h000_0000, route.neg_ground});
        wb(1'b1, ACS_OFF_SAMPLE_SEL, 32'h0000_0d03);
        wb(1'b1, ACS_OFF_CONTROL, 32'h0000_0200);
        repeat (2) @(posedge clk_i);
        for (n = 0; n < 3; n++) begin
            chk("slot", n[0] ? 32'h0000_000d : 32'h0000_0003, {28'h000_0000, route.ext_index});
            conv(1'b0, 1'b0, 4'h0);
        end
        $display("test routing done");
        slow <= 1'b1;
        wb(1'b1, ACS_OFF_CTU_LOW, 32'h0000_0010);
        wb(1'b1, ACS_OFF_SCAN_LOW, 32'h0000_0012);
        wb(1'b1, ACS_OFF_SCAN_HIGH, 32'h0000_0100);
        wb(1'b1, ACS_OFF_CONTROL, 32'h0000_8000);
        foreach (seq[i]) begin
            repeat (40) @(posedge clk_i);
            chk("scan", {27'h000_0000, seq[i]}, {27'h000_0000, scan_ch});
            chk("connect", {31'h000_0000, seq[i] == 5'h04}, {31'h000_0000, ctu});
            conv(1'b0, 1'b0, 4'h0);
        end
        for (n = 0; n < 3; n++) begin
            wb(1'b1, ACS_OFF_CONTROL, n);
            conv(1'b1, 1'b0, 4'h5);
            rd_chk("hit write", ACS_OFF_HIT_LOW, 32'h0000_0000);
        end
        conv(1'b0, 1'b1, 4'h6);
        rd_chk("hit match", ACS_OFF_HIT_LOW, 32'h0000_0040);
        wb(1'b1, ACS_OFF_CONTROL, 32'h0000_0003);
        conv(1'b1, 1'b0, 4'h5);
        conv(1'b0, 1'b1, 4'hd);
        rd_chk("hit outside", ACS_OFF_HIT_LOW, 32'h0000_2060);
        $display("test scan and hits done");
        wb(1'b1, ACS_OFF_BG_CFG, 32'h0000_0000);
        bg_req <= 3'h4;
        repeat (4) @(posedge clk_i);
        chk("bg early", 32'h0000_0000, {29'h000_0000, bg_rdy});
        repeat (12) @(posedge clk_i);
        chk("bg late", 32'h0000_0004, {29'h000_0000, bg_rdy});
        rd_chk("status", ACS_OFF_STATUS, 32'h0000_0040);
        bg_req <= 3'h0;
        for (n = 0; n < 3; n++) begin
            wb(1'b1, ACS_OFF_BG_CFG, 1 << n);
            repeat (2) @(posedge clk_i);
            chk("bg manual", 1 << n, {29'h000_0000, bg_rdy});
        end
        for (n = 2; n < 5; n += 2) begin
            div <= n[7:0];
            repeat (10) @(posedge clk_i);
            cnt = 0;
            repeat (30) begin
                @(posedge clk_i);
                if (tick === 1'b1) cnt++;
            end
            chk("ticks", 30 / (n + 1), cnt);
        end
        $display("test reference and clock done");
        print_verdict();
    end
    // Watchdog: the sequence needs far fewer than 25000 cycles
    initial begin
        #200000;
        errors++;
        print_verdict();
    end
endmodule
bind acs_scan_select acs_scan_select_monitor #(.DIV_WIDTH(DIV_WIDTH)) acs_scan_select_monitor_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .conv_clock_divider_i(conv_clock_divider_i),
    .conv_clock_tick_o(conv_clock_tick_o), .bg_request_i(bg_request_i),
    .bg_ready_o(bg_ready_o), .scan_channel_o(scan_channel_o), .route_o(route_o));

// File: shared/acs_pkg.sv
// Package of constants and carrier types for the converter channel and scan selection block
package acs_pkg;
    // Register word offsets (byte addresses on the 32-bit bus)
    localparam logic [7:0] ACS_OFF_SAMPLE_SEL = 8'h00;
    localparam logic [7:0] ACS_OFF_BG_CFG = 8'h04;
    localparam logic [7:0] ACS_OFF_HIT_LOW = 8'h08;
    localparam logic [7:0] ACS_OFF_SCAN_HIGH = 8'h0c;
    localparam logic [7:0] ACS_OFF_SCAN_LOW = 8'h10;
    localparam logic [7:0] ACS_OFF_CTU_HIGH = 8'h14;
    localparam logic [7:0] ACS_OFF_CTU_LOW = 8'h18;
    localparam logic [7:0] ACS_OFF_CONTROL = 8'h1c;
    localparam logic [7:0] ACS_OFF_STATUS = 8'h20;
    // Writable masks per register
    localparam logic [15:0] ACS_MASK_SAMPLE = 16'hffff;
    localparam logic [15:0] ACS_MASK_BG = 16'h0007;
    localparam logic [15:0] ACS_MASK_HIT_FULL = 16'h3fff;
    localparam logic [15:0] ACS_MASK_HIT_SMALL = 16'h03ff;
    localparam logic [15:0] ACS_MASK_SCAN_HIGH = 16'h1f00;
    localparam logic [15:0] ACS_MASK_SCAN_LOW = 16'hffff;
    localparam logic [15:0] ACS_MASK_CTU_HIGH_FULL = 16'h73ff;
    localparam logic [15:0] ACS_MASK_CTU_HIGH_64PIN = 16'h7300;
    localparam logic [15:0] ACS_MASK_CTU_LOW = 16'hffff;
    localparam logic [15:0] ACS_MASK_CONTROL = 16'h8303;
    localparam logic [15:0] ACS_RESET_VALUE = 16'h0000;
    // Control register field positions
    localparam int ACS_CTL_AUTO_SCAN_BIT = 15;
    localparam int ACS_CTL_ALT_BIT = 9;
    localparam int ACS_CTL_STEP_BIT = 8;
    localparam int ACS_CTL_CMODE_LSB = 0;
    // Sample select field positions
    localparam int ACS_SLOT_B_LSB = 8;
    // Selector codes
    localparam logic [2:0] ACS_NEG_GROUND = 3'h0;
    localparam logic [4:0] ACS_POS_LAST_EXT = 5'h0d;
    localparam logic [4:0] ACS_POS_CTU_TEMP = 5'h0e;
    localparam logic [4:0] ACS_POS_CTU_GEN = 5'h0f;
    localparam logic [4:0] ACS_POS_RES_LO = 5'h10;
    localparam logic [4:0] ACS_POS_RES_HI = 5'h1b;
    localparam logic [4:0] ACS_POS_BANDGAP = 5'h1c;
    localparam logic [4:0] ACS_POS_GROUND = 5'h1d;
    localparam logic [4:0] ACS_POS_SUPPLY = 5'h1e;
    localparam logic [1:0] ACS_CMODE_OUTSIDE = 2'h3;
    // Channel map widths
    localparam int ACS_CHANNELS = 32;
    localparam int ACS_HITS = 14;
    // Band-gap start-up time
    localparam int ACS_CLK_MHZ = 125;
    localparam int ACS_BG_STARTUP_US = 1000;
    localparam int ACS_BG_STARTUP_CYC = ACS_BG_STARTUP_US * ACS_CLK_MHZ;

    // Decoded analog input routing for the multiplexer
    typedef struct packed {
        logic ext_valid;      // External input routed
        logic [3:0] ext_index; // External input number
        logic ctu_temp;       // Charge-time unit temperature path
        logic ctu_general;    // Charge-time unit measurement path
        logic bandgap;        // Band-gap voltage
        logic ground;         // Analog ground
        logic supply;         // Analog supply
        logic reserved;       // Reserved or unimplemented code
        logic neg_ground;     // Negative input on analog ground
    } acs_route_s;

    // Conversion-side event group
    typedef struct packed {
        logic result_write;   // A result buffer was written
        logic match;          // Valid compare match
        logic [3:0] channel;  // Result channel of the event
    } acs_event_s;
endpackage

// File: verilog/acs_bandgap_start.sv
`timescale 1ns/1ns
// Band-gap reference start-up timer for one reference
module acs_bandgap_start #(
    parameter int DELAY_CYC = acs_pkg::ACS_BG_STARTUP_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic manual_i,
    input wire logic request_i,
    output logic ready_o
);
    import acs_pkg::*;
    localparam int CW = $clog2(DELAY_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(DELAY_CYC - 1);
    logic [CW-1:0] count_q; // Start-up cycles so far
    logic ready_q;          // Reference settled

    // Manual enable bypasses the wait; a request waits the full start-up time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= '0;
            ready_q <= 1'b0;
        end else if (ce_i) begin
            if (manual_i) begin
                ready_q <= 1'b1;
                count_q <= '0;
            end else if (!request_i) begin
                // Dropping the request powers the reference down again
                ready_q <= 1'b0;
                count_q <= '0;
            end else if (!ready_q) begin
                if (count_q == LAST) begin
                    ready_q <= 1'b1;
                end else begin
                    count_q <= count_q + 1'b1;
                end
            end
        end
    end

    assign ready_o = ready_q;
endmodule

// File: verilog/acs_scan_select.sv
`timescale 1ns/1ns
// Converter input, scan, compare-hit, charge-unit and band-gap register block
module acs_scan_select #(
    parameter bit SMALL_PACKAGE = 1'b0,
    parameter bit PKG_64PIN = 1'b0,
    parameter int BG_STARTUP_CYC = acs_pkg::ACS_BG_STARTUP_CYC,
    parameter int DIV_WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Classic Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Converter side
    input wire logic sample_done_i,
    input wire acs_pkg::acs_event_s event_i,
    input wire logic [DIV_WIDTH-1:0] conv_clock_divider_i,
    input wire logic [2:0] bg_request_i,
    output acs_pkg::acs_route_s route_o,
    output logic [4:0] scan_channel_o,
    output logic ctu_connect_o,
    output logic conv_clock_tick_o,
    output logic [2:0] bg_ready_o
);
    import acs_pkg::*;

    // Software-visible registers
    logic [15:0] sample_sel_q;
    logic [15:0] bg_cfg_q;
    logic [15:0] hit_q;
    logic [15:0] scan_high_q;
    logic [15:0] scan_low_q;
    logic [15:0] ctu_high_q;
    logic [15:0] ctu_low_q;
    logic [15:0] control_q;
    // Block state
    logic slot_b_q;          // Current sample uses slot B
    logic [4:0] scan_ch_q;   // Channel under conversion in auto-scan
    logic [DIV_WIDTH-1:0] div_q; // Conversion clock divider count
    logic tick_q;            // One-cycle conversion clock tick
    logic ack_q;             // Bus acknowledge
    logic [31:0] rdata_q;    // Registered read data
    acs_route_s route_q;     // Registered route to the multiplexer
    logic ctu_q;             // Registered charge-unit connect

    // Implemented-bit masks depend on package variant
    localparam logic [15:0] HIT_MASK = SMALL_PACKAGE ? ACS_MASK_HIT_SMALL : ACS_MASK_HIT_FULL;
    localparam logic [15:0] CTU_HIGH_MASK =
        PKG_64PIN ? ACS_MASK_CTU_HIGH_64PIN : ACS_MASK_CTU_HIGH_FULL;

    logic bus_req;   // Fresh request this cycle
    logic wr_en;     // Write strobe
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_en = bus_req & wb_we_i & ce_i;

    // Merge byte lanes of the low half word under a mask
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] mask);
        logic [15:0] nv;
        nv = old;
        if (wb_sel_i[0]) begin
            nv[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
            nv[15:8] = wb_dat_i[15:8];
        end
        merge = nv & mask;
    endfunction

    // Decode a slot's selector pair into routing
    function automatic acs_route_s decode(input logic [2:0] neg, input logic [4:0] pos);
        acs_route_s r;
        r = '0;
        r.neg_ground = (neg == ACS_NEG_GROUND);
        if (neg != ACS_NEG_GROUND) begin
            r.reserved = 1'b1;
        end
        if (pos <= ACS_POS_LAST_EXT) begin
            r.ext_valid = 1'b1;
            r.ext_index = pos[3:0];
        end
        r.ctu_temp = (pos == ACS_POS_CTU_TEMP);
        r.ctu_general = (pos == ACS_POS_CTU_GEN);
        r.bandgap = (pos == ACS_POS_BANDGAP);
        r.ground = (pos == ACS_POS_GROUND);
        r.supply = (pos == ACS_POS_SUPPLY);
        if ((pos >= ACS_POS_RES_LO && pos <= ACS_POS_RES_HI) || pos > ACS_POS_SUPPLY) begin
            r.reserved = 1'b1;
        end
        // unimplemented negative code routes nothing at all
        if (neg != ACS_NEG_GROUND) begin
            r = '0;
            r.reserved = 1'b1;
        end
        decode = r;
    endfunction

    logic [31:0] scan_mask;  // Scan selection by channel number
    logic [31:0] ctu_mask;   // Charge-unit connect by channel number
    assign scan_mask = {3'b000, scan_high_q[12:8], 8'h00, scan_low_q};
    assign ctu_mask = {1'b0, ctu_high_q[14:12], 2'b00, ctu_high_q[9:0], ctu_low_q};

    // Next selected channel above a given one, wrapping to the lowest
    function automatic logic [4:0] next_scan(input logic [4:0] cur, input logic [31:0] m);
        logic [4:0] nxt;
        logic found;
        nxt = cur;
        found = 1'b0;
        for (int i = 1; i <= ACS_CHANNELS; i++) begin
            if (!found && m[5'(cur + 5'(i))]) begin
                nxt = 5'(cur + 5'(i));
                found = 1'b1;
            end
        end
        next_scan = nxt;
    endfunction

    logic auto_scan;    // Auto-scan on
    logic alt_option;   // Alternate sample option
    logic [1:0] cmode;  // Compare mode
    assign auto_scan = control_q[ACS_CTL_AUTO_SCAN_BIT];
    assign alt_option = control_q[ACS_CTL_ALT_BIT];
    assign cmode = control_q[ACS_CTL_CMODE_LSB +: 2];

    // Configuration registers; writes masked so unimplemented bits stay zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_sel_q <= ACS_RESET_VALUE;
            bg_cfg_q <= ACS_RESET_VALUE;
            scan_high_q <= ACS_RESET_VALUE;
            scan_low_q <= ACS_RESET_VALUE;
            ctu_high_q <= ACS_RESET_VALUE;
            ctu_low_q <= ACS_RESET_VALUE;
            control_q <= ACS_RESET_VALUE;
        end else if (wr_en) begin
            unique case (wb_adr_i)
                ACS_OFF_SAMPLE_SEL: sample_sel_q <= merge(sample_sel_q, ACS_MASK_SAMPLE);
                ACS_OFF_BG_CFG: bg_cfg_q <= merge(bg_cfg_q, ACS_MASK_BG);
                ACS_OFF_SCAN_HIGH: scan_high_q <= merge(scan_high_q, ACS_MASK_SCAN_HIGH);
                ACS_OFF_SCAN_LOW: scan_low_q <= merge(scan_low_q, ACS_MASK_SCAN_LOW);
                ACS_OFF_CTU_HIGH: ctu_high_q <= merge(ctu_high_q, CTU_HIGH_MASK);
                ACS_OFF_CTU_LOW: ctu_low_q <= merge(ctu_low_q, ACS_MASK_CTU_LOW);
                ACS_OFF_CONTROL: control_q <= merge(control_q, ACS_MASK_CONTROL);
                default: ;
            endcase
        end
    end

    // Compare-hit flags: hardware set wins over a software write
    always_ff @(posedge clk_i) begin
        logic [15:0] hv;
        logic [15:0] setv;
        hv = hit_q;
        setv = '0;
        if (rst_i) begin
            hit_q <= ACS_RESET_VALUE;
        end else if (ce_i) begin
            if (wr_en && wb_adr_i == ACS_OFF_HIT_LOW) begin
                hv = merge(hit_q, HIT_MASK);
            end
            if (cmode == ACS_CMODE_OUTSIDE) begin
                setv[event_i.channel] = event_i.result_write | event_i.match;
            end else begin
                setv[event_i.channel] = event_i.match;
            end
            hit_q <= (hv | setv) & HIT_MASK;
        end
    end

    // Sample sequencing: slot alternation and scan stepping per finished sample
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slot_b_q <= 1'b0;
            scan_ch_q <= '0;
        end else if (ce_i) begin
            if (!alt_option) begin
                slot_b_q <= 1'b0;
            end else if (sample_done_i) begin
                slot_b_q <= ~slot_b_q;
            end
            if (!auto_scan || scan_mask == '0) begin
                scan_ch_q <= '0;
            end else if (sample_done_i || !scan_mask[scan_ch_q]) begin
                scan_ch_q <= next_scan(scan_ch_q, scan_mask);
            end
        end
    end

    // Routing to the multiplexer from the active slot
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            route_q <= '0;
            ctu_q <= 1'b0;
        end else if (ce_i) begin
            if (slot_b_q) begin
                route_q <= decode(sample_sel_q[ACS_SLOT_B_LSB+5 +: 3],
                    sample_sel_q[ACS_SLOT_B_LSB +: 5]);
            end else begin
                route_q <= decode(sample_sel_q[7:5], sample_sel_q[4:0]);
            end
            ctu_q <= auto_scan ? ctu_mask[scan_ch_q]
                : ctu_mask[{1'b0, sample_sel_q[3:0]}];
        end
    end

    // Conversion clock: one tick every divider+1 cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else if (ce_i) begin
            if (div_q >= conv_clock_divider_i) begin
                div_q <= '0;
                tick_q <= 1'b1;
            end else begin
                div_q <= div_q + 1'b1;
                tick_q <= 1'b0;
            end
        end
    end

    // Band-gap start-up timers, one per reference
    for (genvar g = 0; g < 3; g++) begin : g_bg
        acs_bandgap_start #(
            .DELAY_CYC(BG_STARTUP_CYC)
        ) u_bg (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .manual_i(bg_cfg_q[g]),
            .request_i(bg_request_i[g]),
            .ready_o(bg_ready_o[g])
        );
    end

    // Bus answer: one-cycle ack after request, unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
        end else if (ce_i) begin
            ack_q <= bus_req;
            if (bus_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    ACS_OFF_SAMPLE_SEL: rdata_q <= {16'h0000, sample_sel_q};
                    ACS_OFF_BG_CFG: rdata_q <= {16'h0000, bg_cfg_q};
                    ACS_OFF_HIT_LOW: rdata_q <= {16'h0000, hit_q};
                    ACS_OFF_SCAN_HIGH: rdata_q <= {16'h0000, scan_high_q};
                    ACS_OFF_SCAN_LOW: rdata_q <= {16'h0000, scan_low_q};
                    ACS_OFF_CTU_HIGH: rdata_q <= {16'h0000, ctu_high_q};
                    ACS_OFF_CTU_LOW: rdata_q <= {16'h0000, ctu_low_q};
                    ACS_OFF_CONTROL: rdata_q <= {16'h0000, control_q};
                    ACS_OFF_STATUS: rdata_q <= {16'h0000, 8'h00, slot_b_q, bg_ready_o,
                        scan_ch_q[3:0]} | {31'h0000_0000, 1'b0} |
                        {27'h0000_000, scan_ch_q[4], 4'h0} << 8;
                    default: rdata_q <= '0;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign route_o = route_q;
    assign ctu_connect_o = ctu_q;
    assign scan_channel_o = scan_ch_q;
    assign conv_clock_tick_o = tick_q;
endmodule
